//--- hw/atc_core.sv
// auto tuning control core with apb register slave
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/100ps
// Operation
// - one global coarse divider 5 bits and coarse multiplier 4 bits for trackpad
// - one global fine divider 5 bits, fine multiplier 2 bits limited 0..2
// - tuning picks a compensation so the count reaches the tuning target
// - compensation is 10 bits; a 5-bit compensation divider is set with it
// - host sets trackpad request; device clears it when tuning completes
// - trackpad re-tune runs only in active, idle-touch or idle mode
// - tuning starts only after the communication window closes; bus stalls meanwhile
// - proximity has full tuning and compensation-only modes, with base and tuning targets
// - full tuning reaches base target with dividers first, then compensation
// - proximity target applies per engine count, so the sum exceeds it
// - compensation-only proximity tuning works like the trackpad tuning
// - proximity keeps compensation and divider per each of 13 engines
// - proximity request runs only in low power modes one or two, then clears
// - auto re-tune enable bits allow triggers per channel group
// - each automatic re-tune pulses the matching re-tune occurred flag
// - reference outside target plus or minus drift limit triggers re-tune
// - negative delta beyond threshold for 15 cycles triggers re-tune
// - positive delta above threshold for 15 cycles triggers re-tune
// - error if compensation is 0, 1023, or reference outside re-tune range
// - error flag set on error, updated only by a new tuning run
// - after an error auto re-tune is held off for retry time, max 60 s
// - trackpad delta is count minus reference, signed
module atc_core
   import atc_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // device context
   input wire atc_mode_t mode,
   input wire logic comm_window,
   input wire logic sec_tick,
   input wire atc_sample_t sample,
   // tuning outputs to the front end
   output atc_divs_t tp_divs,
   output atc_divs_t px_divs,
   output logic [9:0] tp_comp,
   output logic [4:0] tp_comp_div,
   output logic tuning_busy
);

   // whole block state
   typedef struct packed {
      logic tp_req;
      logic px_req;
      logic [31:0] cfg;
      atc_divs_t tp_divs;
      atc_divs_t px_divs;
      logic [31:0] target;
      logic [31:0] drift;
      logic [31:0] delta_thr;
      logic [9:0] tp_comp;
      logic [4:0] tp_comp_div;
      logic [ATC_PX_ENGINES*15-1:0] px_comp;
      atc_state_t st;
      logic run_px;
      logic run_auto;
      logic [4:0] step;
      logic err;
      logic tp_err;
      logic px_err;
      logic tp_occ;
      logic px_occ;
      logic [5:0] retry_s;
      logic [3:0] neg_cnt;
      logic [3:0] pos_cnt;
      logic tp_auto_pend;
      logic px_auto_pend;
      logic [31:0] rdata;
   } atc_state_s_t;

   atc_state_s_t s_q, s_d;

   logic wr_en, rd_en, stall;
   logic signed [16:0] delta;
   logic [15:0] tgt, drl;
   logic out_range, tp_trig, px_trig, retry_idle;
   logic [9:0] comp_step;
   logic [14:0] pxe;

   //--------------------------------------------------------------
   // bus access
   //--------------------------------------------------------------
   // the bus is held off while a tuning routine runs
   assign stall = (s_q.st != ATC_WAIT);
   assign pready = !stall;
   assign wr_en = psel && penable && pwrite && pready;
   assign rd_en = psel && !penable && !pwrite;
   assign pslverr = 1'b0;
   assign prdata = s_q.rdata;
   assign tp_divs = s_q.tp_divs;
   assign px_divs = s_q.px_divs;
   assign tp_comp = s_q.tp_comp;
   assign tp_comp_div = s_q.tp_comp_div;
   assign tuning_busy = stall;

   //--------------------------------------------------------------
   // trigger detection
   //--------------------------------------------------------------
   // signed delta and drift window
   assign delta = $signed({1'b0, sample.count}) - $signed({1'b0, sample.reference});
   assign tgt = sample.is_prox ? s_q.target[31:16] : s_q.target[15:0];
   assign drl = sample.is_prox ? s_q.drift[31:16] : s_q.drift[15:0];
   assign out_range = ({1'b0, sample.reference} > {1'b0, tgt} + {1'b0, drl}) ||
                      ({1'b0, sample.reference} + {1'b0, drl} < {1'b0, tgt});
   assign retry_idle = (s_q.retry_s == 6'h00);
   assign tp_trig = sample.valid && !sample.is_prox && s_q.cfg[ATC_TP_AUTO_BIT] && retry_idle &&
                    (out_range || ((s_q.neg_cnt >= ATC_PERSIST_CYCLES - 4'h1) &&
                     (-delta > $signed({1'b0, s_q.delta_thr[15:0]}))) ||
                     ((s_q.pos_cnt >= ATC_PERSIST_CYCLES - 4'h1) &&
                     (delta > $signed({1'b0, s_q.delta_thr[31:16]}))));
   assign px_trig = sample.valid && sample.is_prox && s_q.cfg[ATC_PX_AUTO_BIT] && retry_idle &&
                    out_range;
   assign comp_step = 10'(s_q.step) << 5;
   assign pxe = {s_q.tp_comp_div, comp_step};

   //--------------------------------------------------------------
   // next state
   //--------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.tp_occ = 1'b0;
      s_d.px_occ = 1'b0;
      // register writes
      if (wr_en) begin
         case (paddr)
            ATC_CTRL_OFF: begin
               s_d.tp_req = s_q.tp_req | pwdata[ATC_TP_REQ_BIT];
               s_d.px_req = s_q.px_req | pwdata[ATC_PX_REQ_BIT];
            end
            ATC_CFG_OFF: begin
               s_d.cfg = pwdata;
               if (pwdata[ATC_RETRY_LSB +: 6] > ATC_RETRY_MAX_S) begin
                  s_d.cfg[ATC_RETRY_LSB +: 6] = ATC_RETRY_MAX_S;
               end
            end
            ATC_TP_DIV_OFF: begin
               s_d.tp_divs = atc_divs_t'(pwdata[15:0]);
               if (pwdata[15:14] > ATC_FINE_MUL_MAX) begin
                  s_d.tp_divs.fine_mul = ATC_FINE_MUL_MAX;
               end
            end
            ATC_TARGET_OFF: s_d.target = pwdata;
            ATC_DRIFT_OFF: s_d.drift = pwdata;
            ATC_DELTA_OFF: s_d.delta_thr = pwdata;
            default: begin
            end
         endcase
      end
      // persistence counters for delta excursions
      if (sample.valid && !sample.is_prox) begin
         s_d.neg_cnt = (-delta > $signed({1'b0, s_q.delta_thr[15:0]})) ?
                       ((s_q.neg_cnt == ATC_PERSIST_CYCLES) ? s_q.neg_cnt : s_q.neg_cnt + 4'h1) : 4'h0;
         s_d.pos_cnt = (delta > $signed({1'b0, s_q.delta_thr[31:16]})) ?
                       ((s_q.pos_cnt == ATC_PERSIST_CYCLES) ? s_q.pos_cnt : s_q.pos_cnt + 4'h1) : 4'h0;
      end
      if (tp_trig) begin
         s_d.tp_auto_pend = 1'b1;
      end
      if (px_trig) begin
         s_d.px_auto_pend = 1'b1;
      end
      // retry hold-off countdown on the seconds tick
      if (sec_tick && !retry_idle) begin
         s_d.retry_s = s_q.retry_s - 6'h01;
      end
      // tuning sequencer
      case (s_q.st)
         ATC_WAIT: begin
            if (!comm_window) begin
               if ((s_q.tp_req || s_q.tp_auto_pend) &&
                   (mode == ATC_ACTIVE || mode == ATC_IDLE_TOUCH || mode == ATC_IDLE)) begin
                  s_d.st = ATC_BASE;
                  s_d.run_px = 1'b0;
                  s_d.run_auto = s_q.tp_auto_pend && !s_q.tp_req;
                  s_d.step = 5'h00;
               end else if ((s_q.px_req || s_q.px_auto_pend) &&
                            (mode == ATC_LP1 || mode == ATC_LP2)) begin
                  s_d.st = ATC_BASE;
                  s_d.run_px = 1'b1;
                  s_d.run_auto = s_q.px_auto_pend && !s_q.px_req;
                  s_d.step = 5'h00;
               end
            end
         end
         ATC_BASE: begin
            // full proximity tuning sets dividers first; trackpad keeps host dividers
            if (s_q.run_px && s_q.cfg[ATC_PX_MODE_BIT]) begin
               s_d.px_divs = atc_divs_t'({ATC_FINE_MUL_RST, s_q.target[20:16], 4'(s_q.step), s_q.step});
            end else if (s_q.run_px) begin
               s_d.px_divs = s_q.tp_divs;
            end
            s_d.st = ATC_COMP;
            s_d.step = 5'h00;
         end
         ATC_COMP: begin
            // successive approximation toward the per-engine target
            s_d.step = s_q.step + 5'h01;
            if (sample.valid) begin
               if (sample.count < tgt) begin
                  s_d.tp_comp = s_q.tp_comp + (10'h200 >> s_q.step[3:0]);
               end else begin
                  s_d.tp_comp = s_q.tp_comp - (10'h200 >> s_q.step[3:0]);
               end
            end
            s_d.tp_comp_div = s_q.step;
            if (s_q.step == ATC_SETTLE_CYCLES - 5'h01) begin
               s_d.st = ATC_CHECK;
            end
         end
         ATC_CHECK: begin
            s_d.err = (s_q.tp_comp == 10'h000) || (s_q.tp_comp == ATC_COMP_MAX) ||
                      (sample.valid && out_range);
            s_d.st = ATC_DONE;
         end
         ATC_DONE: begin
            if (s_q.run_px) begin
               s_d.px_err = s_q.err;
               s_d.px_req = 1'b0;
               s_d.px_auto_pend = 1'b0;
               s_d.px_occ = s_q.run_auto;
               s_d.px_comp[15*sample.engine +: 15] = pxe;
            end else begin
               s_d.tp_err = s_q.err;
               s_d.tp_req = 1'b0;
               s_d.tp_auto_pend = 1'b0;
               s_d.tp_occ = s_q.run_auto;
            end
            if (s_q.err) begin
               s_d.retry_s = s_q.cfg[ATC_RETRY_LSB +: 6];
            end
            s_d.st = ATC_WAIT;
         end
         default: s_d.st = ATC_WAIT;
      endcase
      // read data latched in setup phase
      if (rd_en) begin
         case (paddr)
            ATC_CTRL_OFF: s_d.rdata = {30'h0, s_q.px_req, s_q.tp_req};
            ATC_CFG_OFF: s_d.rdata = s_q.cfg;
            ATC_TP_DIV_OFF: s_d.rdata = {16'h0, s_q.tp_divs};
            ATC_PX_DIV_OFF: s_d.rdata = {16'h0, s_q.px_divs};
            ATC_TARGET_OFF: s_d.rdata = s_q.target;
            ATC_DRIFT_OFF: s_d.rdata = s_q.drift;
            ATC_DELTA_OFF: s_d.rdata = s_q.delta_thr;
            ATC_INFO_OFF: s_d.rdata = {18'h0, s_q.retry_s, 4'h0, s_q.px_occ, s_q.tp_occ, s_q.px_err, s_q.tp_err};
            ATC_COMP_OFF: s_d.rdata = {17'h0, s_q.tp_comp_div, s_q.tp_comp};
            ATC_PXCOMP_OFF: s_d.rdata = {17'h0, s_q.px_comp[15*pwdata[3:0] +: 15]};
            default: s_d.rdata = 32'h0;
         endcase
      end
   end

   //--------------------------------------------------------------
   // state register
   //--------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
         s_q.cfg <= ATC_CFG_RST;
         s_q.tp_divs <= atc_divs_t'(ATC_TP_DIV_RST[15:0]);
         s_q.target <= ATC_TARGET_RST;
         s_q.drift <= ATC_DRIFT_RST;
         s_q.delta_thr <= ATC_DELTA_RST;
         s_q.st <= ATC_WAIT;
      end else begin
         s_q <= s_d;
      end
   end

   //--------------------------------------------------------------
   // checks
   //--------------------------------------------------------------
   property p_start_gate;
      @(posedge mclk) disable iff (rst) (s_q.st == ATC_WAIT && s_d.st == ATC_BASE) |-> !comm_window;
   endproperty
   a_start_gate: assert property (p_start_gate) else $error("tuning started in comm window");

   property p_tp_mode;
      @(posedge mclk) disable iff (rst)
         (s_q.st == ATC_WAIT && s_d.st == ATC_BASE && !s_d.run_px) |-> (mode inside {ATC_ACTIVE, ATC_IDLE_TOUCH, ATC_IDLE});
   endproperty
   a_tp_mode: assert property (p_tp_mode) else $error("trackpad tuning in wrong mode");

   property p_px_mode;
      @(posedge mclk) disable iff (rst)
         (s_q.st == ATC_WAIT && s_d.st == ATC_BASE && s_d.run_px) |-> (mode inside {ATC_LP1, ATC_LP2});
   endproperty
   a_px_mode: assert property (p_px_mode) else $error("prox tuning in wrong mode");

   property p_tp_clear;
      @(posedge mclk) disable iff (rst) (s_q.st == ATC_DONE && !s_q.run_px) |=> !s_q.tp_req;
   endproperty
   a_tp_clear: assert property (p_tp_clear) else $error("trackpad request not cleared");

   property p_px_clear;
      @(posedge mclk) disable iff (rst) (s_q.st == ATC_DONE && s_q.run_px) |=> !s_q.px_req;
   endproperty
   a_px_clear: assert property (p_px_clear) else $error("prox request not cleared");

   property p_occ_auto;
      @(posedge mclk) disable iff (rst) (s_q.st == ATC_DONE && s_q.run_auto) |=> (s_q.tp_occ || s_q.px_occ);
   endproperty
   a_occ_auto: assert property (p_occ_auto) else $error("re-tune occurred flag missing");

   property p_occ_pulse;
      @(posedge mclk) disable iff (rst) s_q.tp_occ |=> !s_q.tp_occ;
   endproperty
   a_occ_pulse: assert property (p_occ_pulse) else $error("occurred flag not a pulse");

   property p_err_hold;
      @(posedge mclk) disable iff (rst) (s_q.st != ATC_DONE) |=> (s_q.tp_err == $past(s_q.tp_err));
   endproperty
   a_err_hold: assert property (p_err_hold) else $error("error flag changed outside run");

   property p_retry_block;
      @(posedge mclk) disable iff (rst)
         (s_q.retry_s != 6'h00 && !s_q.tp_auto_pend && !s_q.px_auto_pend) |=> !s_q.tp_auto_pend && !s_q.px_auto_pend;
   endproperty
   a_retry_block: assert property (p_retry_block) else $error("trigger during retry hold-off");

   property p_retry_max;
      @(posedge mclk) disable iff (rst) s_q.retry_s <= ATC_RETRY_MAX_S;
   endproperty
   a_retry_max: assert property (p_retry_max) else $error("retry time above limit");

   property p_fine_mul;
      @(posedge mclk) disable iff (rst) s_q.tp_divs.fine_mul <= ATC_FINE_MUL_MAX;
   endproperty
   a_fine_mul: assert property (p_fine_mul) else $error("fine multiplier out of range");

   property p_busy_len;
      @(posedge mclk) disable iff (rst) $rose(stall) |-> stall [*8];
   endproperty
   a_busy_len: assert property (p_busy_len) else $error("tuning routine too short");

   c_tp_run: cover property (@(posedge mclk) disable iff (rst) s_q.st == ATC_DONE && !s_q.run_px);
   c_px_run: cover property (@(posedge mclk) disable iff (rst) s_q.st == ATC_DONE && s_q.run_px);
   c_auto: cover property (@(posedge mclk) disable iff (rst) s_q.tp_occ);
   c_err: cover property (@(posedge mclk) disable iff (rst) s_q.retry_s != 6'h00);
endmodule

//--- hw/atc_pkg.sv
// package for the auto tuning control block
package atc_pkg;
   // register byte offsets
   localparam logic [7:0] ATC_CTRL_OFF = 8'h00;
   localparam logic [7:0] ATC_CFG_OFF = 8'h04;
   localparam logic [7:0] ATC_TP_DIV_OFF = 8'h08;
   localparam logic [7:0] ATC_PX_DIV_OFF = 8'h0c;
   localparam logic [7:0] ATC_TARGET_OFF = 8'h10;
   localparam logic [7:0] ATC_DRIFT_OFF = 8'h14;
   localparam logic [7:0] ATC_DELTA_OFF = 8'h18;
   localparam logic [7:0] ATC_INFO_OFF = 8'h1c;
   localparam logic [7:0] ATC_COMP_OFF = 8'h20;
   localparam logic [7:0] ATC_PXCOMP_OFF = 8'h24;
   // control bit positions
   localparam int ATC_TP_REQ_BIT = 0;
   localparam int ATC_PX_REQ_BIT = 1;
   // cfg field positions
   localparam int ATC_TP_AUTO_BIT = 0;
   localparam int ATC_PX_AUTO_BIT = 1;
   localparam int ATC_PX_MODE_BIT = 2;
   localparam int ATC_RETRY_LSB = 8;
   // sizes and limits
   localparam int ATC_COMP_W = 10;
   localparam logic [9:0] ATC_COMP_MAX = 10'h3ff;
   localparam int ATC_PX_ENGINES = 13;
   localparam logic [3:0] ATC_PERSIST_CYCLES = 4'hf;
   localparam logic [5:0] ATC_RETRY_MAX_S = 6'h3c;
   localparam logic [1:0] ATC_FINE_MUL_MAX = 2'h2;
   localparam logic [4:0] ATC_SETTLE_CYCLES = 5'h10;
   // reset values
   localparam logic [31:0] ATC_CFG_RST = 32'h0000_0a03;
   localparam logic [31:0] ATC_TP_DIV_RST = 32'h0000_0000;
   localparam logic [31:0] ATC_TARGET_RST = 32'h0100_0320;
   localparam logic [31:0] ATC_DRIFT_RST = 32'h0032_0032;
   localparam logic [31:0] ATC_DELTA_RST = 32'h0040_0040;
   localparam logic [1:0] ATC_FINE_MUL_RST = 2'h1;

   // operating modes of the device
   typedef enum logic [2:0] {ATC_ACTIVE, ATC_IDLE_TOUCH, ATC_IDLE, ATC_LP1, ATC_LP2} atc_mode_t;
   // tuning sequencer states
   typedef enum logic [2:0] {ATC_WAIT, ATC_BASE, ATC_COMP, ATC_CHECK, ATC_DONE} atc_state_t;

   // shared divider/multiplier set
   typedef struct packed {
      logic [1:0] fine_mul;
      logic [4:0] fine_div;
      logic [3:0] coarse_mul;
      logic [4:0] coarse_div;
   } atc_divs_t;

   // measurement sample from the sensing front end
   typedef struct packed {
      logic valid;
      logic is_prox;
      logic [3:0] engine;
      logic [15:0] count;
      logic [15:0] reference;
   } atc_sample_t;
endpackage

//--- verification/atc_front_model.sv
// sensing front end model feeding count and reference samples
`timescale 1ns/100ps
module atc_front_model
   import atc_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // sample request from the bench
   input wire logic on,
   input wire logic is_prox,
   input wire logic [15:0] cnt,
   input wire logic [15:0] ref_v,
   // sample towards the block
   output atc_sample_t sample
);
   logic [1:0] ph_q;
   // one conversion every four clocks while on; stale fields are inverted when off
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ph_q <= 2'h0;
         sample <= '0;
      end else begin
         ph_q <= ph_q + 2'h1;
         sample.valid <= on && (ph_q == 2'h0);
         sample.is_prox <= is_prox;
         sample.engine <= 4'h0;
         sample.count <= on ? cnt : ~sample.count;
         sample.reference <= on ? ref_v : ~sample.reference;
      end
   end
endmodule

//--- verification/auto_tuning_control_test.sv
// self-checking bench for the auto tuning control core
`timescale 1ns/100ps
module auto_tuning_control_test;
   import atc_pkg::*;
   logic mclk, rst, psel, penable, pwrite, pready, pslverr, comm_window, sec_tick, tuning_busy;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, d;
   atc_mode_t mode;
   atc_sample_t sample;
   atc_divs_t tp_divs, px_divs;
   logic [9:0] tp_comp;
   logic [4:0] tp_comp_div;
   logic on, ok, px, e;
   logic [15:0] cnt, ref_v;
   int errors, total_checks, wt, seed;

   atc_core dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mode(mode),
      .comm_window(comm_window), .sec_tick(sec_tick), .sample(sample), .tp_divs(tp_divs),
      .px_divs(px_divs), .tp_comp(tp_comp), .tp_comp_div(tp_comp_div), .tuning_busy(tuning_busy));
   atc_front_model fe (.mclk(mclk), .rst(rst), .on(on), .is_prox(px), .cnt(cnt), .ref_v(ref_v),
      .sample(sample));

   // ----------------------------------------
   // bench tasks
   // ----------------------------------------
   task automatic results;
      if (errors == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         errors++;
         $display("mismatch at %0t: got %h want %h", $time, s, e);
      end
   endtask

   // one apb transfer, pready sampled at each rising edge of the access phase
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      wt = 0;
      do begin
         @(posedge mclk);
         wt++;
      end while (pready !== 1'b1 && wt < 300);
      rd = prdata;
      chk({31'h0, pslverr}, 32'h0);
      psel <= 1'b0;
      penable <= 1'b0;
      if (wt >= 300) begin
         errors++;
         results();
      end
   endtask

   // bounded wait for the busy level
   task automatic wbusy(input logic v, input int lim);
      ok = 1'b0;
      for (int n = 0; n < lim && !ok; n++) begin
         @(negedge mclk);
         if (tuning_busy === v) ok = 1'b1;
      end
      @(posedge mclk);
   endtask

   function automatic logic [31:0] tpexp(input logic [31:0] w);
      tpexp = {16'h0, (w[15:14] > ATC_FINE_MUL_MAX) ? ATC_FINE_MUL_MAX : w[15:14], w[13:0]};
   endfunction

   function automatic logic runs(input atc_mode_t m, input int b);
      runs = (b == 0) ? (m inside {ATC_ACTIVE, ATC_IDLE_TOUCH, ATC_IDLE}) : (m inside {ATC_LP1, ATC_LP2});
   endfunction

   // ----------------------------------------
   // clock and main sequence
   // ----------------------------------------
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   initial begin
      {psel, penable, pwrite, paddr, pwdata, comm_window, sec_tick, on, px} = '0;
      mode = ATC_ACTIVE;
      cnt = 16'h0;
      ref_v = 16'h0;
      errors = 0;
      total_checks = 0;
      seed = 18374;
      rst = 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      // reset values and an unmapped place
      apb(0, ATC_CFG_OFF, 0); chk(rd, ATC_CFG_RST);
      apb(0, ATC_TP_DIV_OFF, 0); chk(rd, ATC_TP_DIV_RST);
      apb(0, ATC_TARGET_OFF, 0); chk(rd, ATC_TARGET_RST);
      apb(0, ATC_DRIFT_OFF, 0); chk(rd, ATC_DRIFT_RST);
      apb(0, ATC_DELTA_OFF, 0); chk(rd, ATC_DELTA_RST);
      apb(1, 8'h40, 32'hffff_ffff);
      apb(0, 8'h40, 0); chk(rd, 32'h0);
      // reference at both drift bounds stays quiet, one past the upper bound tunes
      on <= 1'b1;
      cnt <= 16'd850; ref_v <= 16'd850;
      wbusy(1, 40); chk({31'h0, ok}, 32'h0);
      cnt <= 16'd750; ref_v <= 16'd750;
      wbusy(1, 40); chk({31'h0, ok}, 32'h0);
      apb(1, ATC_CFG_OFF, 32'h0000_0a00);
      cnt <= 16'd851; ref_v <= 16'd851;
      wbusy(1, 40); chk({31'h0, ok}, 32'h0);
      apb(1, ATC_CFG_OFF, ATC_CFG_RST);
      wbusy(1, 40); chk({31'h0, ok}, 32'h1);
      on <= 1'b0;
      wbusy(0, 100); chk({31'h0, ok}, 32'h1);
      // divider fields, fine multiplier clamp corner first
      for (int i = 0; i < 6; i++) begin
         d = (i == 0) ? 32'h0000_ffff : $random(seed);
         apb(1, ATC_TP_DIV_OFF, d);
         apb(0, ATC_TP_DIV_OFF, 0); chk(rd, tpexp(d));
         chk({16'h0, tp_divs}, tpexp(d));
      end
      // retry interval clamp
      apb(1, ATC_CFG_OFF, 32'h0000_3f03);
      apb(0, ATC_CFG_OFF, 0); chk(rd & 32'h3f07, 32'h3c03);
      // request waits for the comm window, stalls the bus, then clears
      comm_window <= 1'b1;
      apb(1, ATC_CTRL_OFF, 32'h1);
      wbusy(1, 30); chk({31'h0, ok}, 32'h0);
      apb(0, ATC_CTRL_OFF, 0); chk({31'h0, rd[0]}, 32'h1);
      comm_window <= 1'b0;
      wbusy(1, 30); chk({31'h0, ok}, 32'h1);
      apb(0, ATC_CTRL_OFF, 0); chk({31'h0, wt > 2}, 32'h1);
      wbusy(0, 100); chk({31'h0, ok}, 32'h1);
      apb(0, ATC_CTRL_OFF, 0); chk({31'h0, rd[0]}, 32'h0);
      // every mode against both requests
      for (int i = 0; i < 10; i++) begin
         mode <= atc_mode_t'(i / 2);
         apb(1, ATC_CTRL_OFF, 32'h1 << (i % 2));
         wbusy(1, 30); chk({31'h0, ok}, {31'h0, runs(atc_mode_t'(i / 2), i % 2)});
         if (!ok) begin
            mode <= (i % 2) ? ATC_LP2 : ATC_IDLE;
            wbusy(1, 30); chk({31'h0, ok}, 32'h1);
         end
         wbusy(0, 100); chk({31'h0, ok}, 32'h1);
         apb(0, ATC_CTRL_OFF, 0); chk({30'h0, rd[1:0]}, 32'h0);
      end
      // error checks, hold-off load and compensation divider after the runs
      apb(0, ATC_COMP_OFF, 0); e = (rd[9:0] == 10'h000 || rd[9:0] == ATC_COMP_MAX);
      chk({27'h0, rd[14:10]}, {27'h0, ATC_SETTLE_CYCLES - 5'h01});
      chk({27'h0, tp_comp_div}, {27'h0, ATC_SETTLE_CYCLES - 5'h01});
      apb(0, ATC_INFO_OFF, 0); chk(rd & 32'h3f03, {18'h0, e ? ATC_RETRY_MAX_S : rd[13:8], 6'h0, e, e});
      // compensation-only proximity copies the trackpad dividers
      apb(0, ATC_PX_DIV_OFF, 0); chk(rd, tpexp(d));
      chk({16'h0, px_divs}, tpexp(d));
      // full proximity tuning picks its own dividers
      apb(1, ATC_CFG_OFF, 32'h0000_3c07);
      mode <= ATC_LP1;
      apb(1, ATC_CTRL_OFF, 32'h2);
      wbusy(1, 30); chk({31'h0, ok}, 32'h1);
      wbusy(0, 100); chk({31'h0, ok}, 32'h1);
      chk({30'h0, px_divs.fine_mul}, {30'h0, ATC_FINE_MUL_RST});
      // persistent negative then positive delta, hold-off runs out first
      mode <= ATC_ACTIVE;
      apb(1, ATC_CFG_OFF, 32'h0000_0103);
      for (int s = 0; s < 2; s++) begin
         repeat (61) begin
            sec_tick <= 1'b1;
            @(posedge mclk);
            sec_tick <= 1'b0;
            repeat (3) @(posedge mclk);
         end
         ref_v <= 16'd800;
         cnt <= s ? 16'd865 : 16'd735;
         on <= 1'b1;
         wbusy(1, 48); chk({31'h0, ok}, 32'h0);
         wbusy(1, 24); chk({31'h0, ok}, 32'h1);
         on <= 1'b0;
         wbusy(0, 100); chk({31'h0, ok}, 32'h1);
      end
      // proximity drift window on its own target and limit
      mode <= ATC_LP1;
      px <= 1'b1;
      sec_tick <= 1'b1;
      cnt <= 16'd306; ref_v <= 16'd306;
      on <= 1'b1;
      @(posedge mclk);
      sec_tick <= 1'b0;
      wbusy(1, 40); chk({31'h0, ok}, 32'h0);
      cnt <= 16'd307; ref_v <= 16'd307;
      wbusy(1, 40); chk({31'h0, ok}, 32'h1);
      on <= 1'b0;
      wbusy(0, 100); chk({31'h0, ok}, 32'h1);
      results();
   end
endmodule
